// File: src/pwil_defines.svh
/*
 * Register indices, field positions and reset values of the port wake
 * and interrupt logic. Assumes inclusion by pwil_top and the testbench only.
 */
`ifndef PWIL_DEFINES_SVH
`define PWIL_DEFINES_SVH

// Register indices; byte address is four times the index
`define PWIL_OFS_WAKE_EVENT 12'h013
`define PWIL_OFS_WAKE_EN    12'h017
`define PWIL_OFS_STATUS     12'h01b
`define PWIL_OFS_MASK       12'h01f
`define PWIL_IDX_GSTAT      16'h0010
`define PWIL_IDX_GEN        16'h0011
`define PWIL_IDX_GCLR       16'h0012
`define PWIL_IDX_MAC0       16'h0030

// Field positions
`define PWIL_BIT_MAGIC  2
`define PWIL_BIT_LINK   1
`define PWIL_BIT_ENERGY 0
`define PWIL_BIT_AN     3
`define PWIL_BIT_PHY    1
`define PWIL_BIT_ACL    0

// Reset values
`define PWIL_RST_BYTE 8'h00
`define PWIL_RST_PORTS 7'h00
`define PWIL_RST_MAC 48'h0000_0000_0000

`endif

// File: src/pwil_pkg.sv
/*
 * Types shared by the port wake and interrupt logic.
 * Assumes seven switch ports numbered 1 to 7.
 */
package pwil_pkg;
    typedef logic [7:1]  pwil_ports_type;
    typedef logic [7:0]  pwil_byte_type;
    typedef logic [47:0] pwil_mac_type;
endpackage

// File: src/pwil_top.sv
/*
 * Per-port wake event and interrupt logic for switch ports 1 to 7,
 * with a classic Wishbone slave for its registers.
 * Assumes detector inputs are one-cycle pulses synchronous to core_clk,
 * except the PHY summaries, which are levels held by the PHY.
 */
// Our own choices: the register addresses and the Wishbone slave port.
// Behaviour
// (R01) Enabled magic packet on a port drives the wake output
// (R02) Magic packet counts only if destination equals switch MAC
// (R03) Enabled link up on a PHY port drives the wake output
// (R04) Enabled energy on a PHY port drives wake; disabled never does
// (R05) Each port 1..7 has its own status and mask byte
// (R06) Status bit 3 reports SGMII autoneg done, port 7 only
// (R07) Status bit 1 summarises PHY interrupts, zero on MAC ports
// (R08) Status bit 0 set by that port's ACL counter interrupt
// (R09) ACL status not cleared by read; mask bit toggle clears it
// (R10) Mask bit one disables the same status bit, zero enables
// (R11) Mask bit 3 port 7 only, bit 1 PHY ports, bit 0 all
// (R12) Reserved bits read zero; all bits reset to zero
// (R13) Wake flags latched per port, cleared by software write
// (R14) Wake is OR of each flag ANDed with its enable; port irq is unmasked OR
`timescale 1ns/1ps
`default_nettype none
`include "pwil_defines.svh"

module pwil_top #(
    parameter pwil_pkg::pwil_ports_type PHY_PORTS = 7'h1f
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [17:0]              wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Detector events
    input  wire pwil_pkg::pwil_ports_type magicSeen,
    input  wire logic [335:0]             magicDestAddr,
    input  wire pwil_pkg::pwil_ports_type linkUpSeen,
    input  wire pwil_pkg::pwil_ports_type energySeen,
    input  wire logic                     sgmiiAnDone,
    input  wire pwil_pkg::pwil_ports_type phyIrqLevel,
    input  wire pwil_pkg::pwil_ports_type aclEvent,
    // Event outputs
    output logic                          wakeEventOutput,
    output pwil_pkg::pwil_ports_type      portIrq,
    output logic                          irq
);
    import pwil_pkg::*;

    pwil_ports_type magicFlagQ, linkFlagQ, energyFlagQ;
    pwil_ports_type magicEnQ, linkEnQ, energyEnQ;
    pwil_ports_type aclStatQ, aclMaskQ, phyMaskQ;
    pwil_ports_type magicHit, phyStat, portHit;
    pwil_ports_type wrWake, wrEn, wrMask;
    pwil_ports_type portIrqQ, gStatQ, gEnQ;
    logic           anStatQ, anMaskQ, ackQ;
    logic           wrStb, rdStb, lane0;
    logic [15:0]    idx;
    logic [11:0]    ofs;
    pwil_mac_type   macQ;
    pwil_byte_type  rdData;

    assign idx   = wb_adr_i[17:2];
    assign ofs   = idx[11:0];
    assign lane0 = wb_sel_i[0];
    // Effects land on the ack edge, where the master samples ack
    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && ackQ;
    assign rdStb = wb_cyc_i && wb_stb_i && !wb_we_i && ackQ;

    // Per-port decode and event qualification
    genvar p;
    for (p = 1; p <= 7; p++) begin : g_port
        assign portHit[p] = (idx[15:12] == 4'(p));
        assign wrWake[p]  = wrStb && lane0 && portHit[p]
                            && ofs == `PWIL_OFS_WAKE_EVENT;
        assign wrEn[p]    = wrStb && lane0 && portHit[p]
                            && ofs == `PWIL_OFS_WAKE_EN;
        assign wrMask[p]  = wrStb && lane0 && portHit[p]
                            && ofs == `PWIL_OFS_MASK;
        assign magicHit[p] = magicSeen[p]
            && magicDestAddr[(p-1)*48 +: 48] == macQ; // see (R02)
    end

    // PHY summary is live; the PHY clears its own causes
    assign phyStat = phyIrqLevel & PHY_PORTS; // see (R07)

    // Bus handshake: ack one cycle after the request, then drops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= wb_cyc_i && wb_stb_i && !ackQ;
        end
    end
    assign wb_ack_o = ackQ;

    // Read multiplexer; unmapped indices read zero
    always_comb begin
        rdData = `PWIL_RST_BYTE;
        for (int n = 1; n <= 7; n++) begin
            if (portHit[n]) begin
                case (ofs)
                    `PWIL_OFS_WAKE_EVENT: begin
                        rdData = {5'h00, magicFlagQ[n],
                                  linkFlagQ[n], energyFlagQ[n]};
                    end
                    `PWIL_OFS_WAKE_EN: begin
                        rdData = {5'h00, magicEnQ[n],
                                  linkEnQ[n], energyEnQ[n]};
                    end
                    `PWIL_OFS_STATUS: begin // see (R05) (R12)
                        rdData = {4'h0, anStatQ && n == 7, 1'b0,
                                  phyStat[n], aclStatQ[n]};
                    end
                    `PWIL_OFS_MASK: begin
                        rdData = {4'h0, anMaskQ && n == 7, 1'b0,
                                  phyMaskQ[n], aclMaskQ[n]};
                    end
                    default: begin
                        rdData = `PWIL_RST_BYTE;
                    end
                endcase
            end
        end
        case (idx)
            `PWIL_IDX_GSTAT: rdData = {gStatQ, 1'b0};
            `PWIL_IDX_GEN:   rdData = {gEnQ, 1'b0};
            default: begin
                for (int b = 0; b < 6; b++) begin
                    if (idx == `PWIL_IDX_MAC0 + 16'(b)) begin
                        rdData = macQ[b*8 +: 8];
                    end
                end
            end
        endcase
    end

    // Read data captured in the request cycle, stands with ack
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ackQ) begin
            wb_dat_o <= {24'h00_0000, rdData};
        end
    end

    // Switch MAC address bytes; byte 0 holds bits 7:0
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            macQ <= `PWIL_RST_MAC;
        end else begin
            for (int b = 0; b < 6; b++) begin
                if (wrStb && lane0 && idx == `PWIL_IDX_MAC0 + 16'(b)) begin
                    macQ[b*8 +: 8] <= wb_dat_i[7:0];
                end
            end
        end
    end

    // Wake enables; link and energy kept only on PHY ports
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            magicEnQ  <= `PWIL_RST_PORTS; // see (R12)
            linkEnQ   <= `PWIL_RST_PORTS;
            energyEnQ <= `PWIL_RST_PORTS;
        end else begin
            for (int n = 1; n <= 7; n++) begin
                if (wrEn[n]) begin
                    magicEnQ[n]  <= wb_dat_i[`PWIL_BIT_MAGIC];
                    linkEnQ[n]   <= wb_dat_i[`PWIL_BIT_LINK]
                                    && PHY_PORTS[n];
                    energyEnQ[n] <= wb_dat_i[`PWIL_BIT_ENERGY]
                                    && PHY_PORTS[n];
                end
            end
        end
    end

    // Wake flags: write one clears, a new detection wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            magicFlagQ  <= `PWIL_RST_PORTS;
            linkFlagQ   <= `PWIL_RST_PORTS;
            energyFlagQ <= `PWIL_RST_PORTS;
        end else begin
            for (int n = 1; n <= 7; n++) begin // see (R13)
                magicFlagQ[n] <= magicHit[n] || (magicFlagQ[n]
                    && !(wrWake[n] && wb_dat_i[`PWIL_BIT_MAGIC]));
                linkFlagQ[n] <= (linkUpSeen[n] && PHY_PORTS[n])
                    || (linkFlagQ[n]
                    && !(wrWake[n] && wb_dat_i[`PWIL_BIT_LINK]));
                energyFlagQ[n] <= (energySeen[n] && PHY_PORTS[n])
                    || (energyFlagQ[n]
                    && !(wrWake[n] && wb_dat_i[`PWIL_BIT_ENERGY]));
            end
        end
    end

    // Wake pin stays up until software clears the flag or enable
    assign wakeEventOutput = |((magicFlagQ & magicEnQ) // see (R01)
        | (linkFlagQ & linkEnQ)                        // see (R03)
        | (energyFlagQ & energyEnQ));                  // see (R04) (R14)

    // Mask bits; unimplemented positions held at zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aclMaskQ <= `PWIL_RST_PORTS;
            phyMaskQ <= `PWIL_RST_PORTS;
            anMaskQ  <= 1'b0;
        end else begin
            for (int n = 1; n <= 7; n++) begin // see (R11)
                if (wrMask[n]) begin
                    aclMaskQ[n] <= wb_dat_i[`PWIL_BIT_ACL];
                    phyMaskQ[n] <= wb_dat_i[`PWIL_BIT_PHY]
                                   && PHY_PORTS[n];
                end
            end
            if (wrMask[7]) begin
                anMaskQ <= wb_dat_i[`PWIL_BIT_AN];
            end
        end
    end

    // ACL status: set wins over the mask-toggle clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aclStatQ <= `PWIL_RST_PORTS;
        end else begin
            for (int n = 1; n <= 7; n++) begin // see (R08) (R09)
                aclStatQ[n] <= aclEvent[n] || (aclStatQ[n]
                    && !(wrMask[n]
                    && wb_dat_i[`PWIL_BIT_ACL] != aclMaskQ[n]));
            end
        end
    end

    // Autoneg done is sticky until a status read of port 7
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            anStatQ <= 1'b0;
        end else begin
            anStatQ <= sgmiiAnDone || (anStatQ // see (R06)
                && !(rdStb && portHit[7] && ofs == `PWIL_OFS_STATUS));
        end
    end

    // Per-port request; mask one disables
    always_comb begin
        for (int n = 1; n <= 7; n++) begin // see (R10) (R14)
            portIrq[n] = (aclStatQ[n] && !aclMaskQ[n])
                || (phyStat[n] && !phyMaskQ[n]);
        end
        portIrq[7] = portIrq[7] || (anStatQ && !anMaskQ);
    end

    // Global sticky status of rising port requests
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            portIrqQ <= `PWIL_RST_PORTS;
            gStatQ   <= `PWIL_RST_PORTS;
            gEnQ     <= `PWIL_RST_PORTS;
        end else begin
            portIrqQ <= portIrq;
            gStatQ <= (portIrq & ~portIrqQ) | (gStatQ
                & ~((wrStb && lane0 && idx == `PWIL_IDX_GCLR)
                ? wb_dat_i[7:1] : `PWIL_RST_PORTS));
            if (wrStb && lane0 && idx == `PWIL_IDX_GEN) begin
                gEnQ <= wb_dat_i[7:1];
            end
        end
    end
    assign irq = |(gStatQ & gEnQ);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    magic_wake_a: assert property ( // see (R01)
        |(magicHit & magicEnQ) |=> wakeEventOutput)
        else $error("Magic packet did not raise wake");
    mac_match_a: assert property ( // see (R02)
        magicSeen[2] && magicDestAddr[95:48] != macQ && !magicFlagQ[2]
        |=> !magicFlagQ[2])
        else $error("Foreign magic packet latched");
    link_wake_a: assert property ( // see (R03)
        linkUpSeen[1] && linkEnQ[1] && PHY_PORTS[1]
        |=> wakeEventOutput)
        else $error("Link up did not raise wake");
    energy_off_a: assert property ( // see (R04)
        energySeen[1] && !energyEnQ[1] && !wakeEventOutput && !(|wrEn)
        && !(|magicHit) && !(|(linkUpSeen & linkEnQ))
        && !(|(energySeen & energyEnQ)) |=> !wakeEventOutput)
        else $error("Disabled energy raised wake");
    status_rsvd_a: assert property ( // see (R05) (R12)
        ackQ && !wb_we_i && $past(ofs) == `PWIL_OFS_STATUS
        |-> wb_dat_o[7:4] == 4'h0 && wb_dat_o[2] == 1'b0)
        else $error("Reserved status bits set");
    an_done_a: assert property ( // see (R06)
        sgmiiAnDone && !anMaskQ && !wrMask[7] ##1 !rdStb && !wrMask[7]
        |-> portIrq[7] ##1 portIrq[7])
        else $error("Autoneg done lost");
    phy_irq_a: assert property ( // see (R07)
        $rose(phyIrqLevel[2]) && PHY_PORTS[2] && !phyMaskQ[2]
        |-> portIrq[2])
        else $error("PHY summary missing");
    acl_set_a: assert property ( // see (R08)
        aclEvent[3] |=> aclStatQ[3] ##1 aclStatQ[3] || $past(wrMask[3]))
        else $error("ACL status not held");
    acl_clear_a: assert property ( // see (R09)
        $changed(aclMaskQ[3]) && !$past(aclEvent[3]) |-> !aclStatQ[3])
        else $error("ACL status survived toggle");
    mask_gate_a: assert property ( // see (R10)
        aclMaskQ[3] && (phyMaskQ[3] || !phyStat[3]) |-> !portIrq[3])
        else $error("Masked cause raised port irq");
    an_mask_a: assert property ( // see (R11)
        wrMask[1] |=> !portIrq[1] || !anStatQ || aclStatQ[1]
        || phyStat[1])
        else $error("Port 1 took autoneg cause");
    ack_pulse_a: assert property (
        ackQ |=> !ackQ)
        else $error("Ack held two cycles");
    irq_level_a: assert property ( // see (R14)
        $rose(portIrq[4]) && gEnQ[4] |=> irq)
        else $error("Interrupt output missed event");

    wake_cov: cover property (magicHit[2] && magicEnQ[2]);
    acl_cov: cover property (aclStatQ[4] ##1 $changed(aclMaskQ[4]));
    irq_cov: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: tb/pwil_pm_model.sv
/*
 * Power controller and host model: counts rising edges of the wake
 * output and of the host interrupt. Assumes one clock, async reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pwil_pm_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Watched levels
    input  wire logic       wakeLevel,
    input  wire logic       irqLevel,
    // Edge counts
    output logic      [7:0] wakeCount,
    output logic      [7:0] irqCount
);
    logic wakeSeen_q;
    logic irqSeen_q;

    // Edges, not levels: a sleeping controller acts once per request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wakeSeen_q <= 1'b0;
            irqSeen_q  <= 1'b0;
            wakeCount  <= 8'h00;
            irqCount   <= 8'h00;
        end else begin
            wakeSeen_q <= wakeLevel;
            irqSeen_q  <= irqLevel;
            if (wakeLevel && !wakeSeen_q) begin
                wakeCount <= wakeCount + 8'h01;
            end
            if (irqLevel && !irqSeen_q) begin
                irqCount <= irqCount + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench for the port wake and interrupt logic.
 * Assumes pwil_top with default PHY_PORTS (ports 1..5 have a PHY).
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwil_defines.svh"

module testbench;
    import pwil_pkg::*;
    localparam pwil_mac_type SWITCH_MAC = 48'h02a5_5a3c_c3e1;
    logic           core_clk;
    logic           rst;
    logic           cyc;
    logic           stb;
    logic           we;
    logic [17:0]    adr;
    logic [3:0]     sel;
    logic [31:0]    datIn;
    logic [31:0]    datOut;
    logic           ack;
    pwil_ports_type magic;
    pwil_ports_type linkUp;
    pwil_ports_type energy;
    pwil_ports_type phyIrq;
    pwil_ports_type acl;
    pwil_ports_type portIrq;
    logic           anDone;
    logic [335:0]   destAddr;
    logic           wake;
    logic           irq;
    logic [7:0]     wakeCount;
    logic [7:0]     irqCount;
    int             mismatches;
    int             compares;

    pwil_top u_pwil_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datIn), .wb_dat_o(datOut), .wb_ack_o(ack),
        .magicSeen(magic), .magicDestAddr(destAddr), .linkUpSeen(linkUp),
        .energySeen(energy), .sgmiiAnDone(anDone), .phyIrqLevel(phyIrq),
        .aclEvent(acl), .wakeEventOutput(wake), .portIrq(portIrq),
        .irq(irq));
    pwil_pm_model u_pwil_pm_model (.core_clk(core_clk), .rst(rst),
        .wakeLevel(wake), .irqLevel(irq), .wakeCount(wakeCount),
        .irqCount(irqCount));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Classic cycle; ack and data are read before the edge's updates land
    task automatic wb(input logic w, input logic [15:0] idx,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {idx, 2'b00};
        sel   <= 4'h1;
        datIn <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rdchk(input string name, input logic [15:0] idx,
                         input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(name, exp, q);
    endtask

    function automatic logic [15:0] pidx(input int p, input logic [11:0] o);
        return {p[3:0], o};
    endfunction

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = '0;
        datIn = '0;
        {magic, linkUp, energy, phyIrq, acl, anDone} = '0;
        destAddr = '0;
        mismatches = 0;
        compares = 0;
        step(20);
        rst <= 1'b0;
        for (int p = 1; p <= 7; p++) begin
            rdchk("status", pidx(p, `PWIL_OFS_STATUS), 32'h0);
            rdchk("mask", pidx(p, `PWIL_OFS_MASK), 32'h0);
            rdchk("wake enable", pidx(p, `PWIL_OFS_WAKE_EN), 32'h0);
        end
        rdchk("unmapped", 16'h0fff, 32'h0);
        wr(pidx(1, `PWIL_OFS_WAKE_EN), 8'hff);
        rdchk("wake enable p1", pidx(1, `PWIL_OFS_WAKE_EN), 32'h07);
        wr(pidx(6, `PWIL_OFS_WAKE_EN), 8'hff);
        rdchk("wake enable p6", pidx(6, `PWIL_OFS_WAKE_EN), 32'h04);
        wr(pidx(1, `PWIL_OFS_MASK), 8'hff);
        rdchk("mask p1", pidx(1, `PWIL_OFS_MASK), 32'h03);
        wr(pidx(7, `PWIL_OFS_MASK), 8'hff);
        rdchk("mask p7", pidx(7, `PWIL_OFS_MASK), 32'h09);
        wr(pidx(1, `PWIL_OFS_MASK), 8'h00);
        wr(pidx(7, `PWIL_OFS_MASK), 8'h00);
        for (int b = 0; b < 6; b++) begin
            wr(`PWIL_IDX_MAC0 + 16'(b), SWITCH_MAC[8*b +: 8]);
        end
        // Magic packet on port 2, wrong address then the switch address
        destAddr[95:48] <= SWITCH_MAC ^ 48'h000000000001;
        magic <= 7'h02;
        step(1);
        magic <= '0;
        rdchk("magic flag miss", pidx(2, `PWIL_OFS_WAKE_EVENT), 32'h0);
        destAddr[95:48] <= SWITCH_MAC;
        magic <= 7'h02;
        step(1);
        magic <= '0;
        step(1);
        chk("wake magic disabled", 32'(0), 32'(wake));
        rdchk("magic flag", pidx(2, `PWIL_OFS_WAKE_EVENT), 32'h04);
        wr(pidx(2, `PWIL_OFS_WAKE_EN), 8'h04);
        step(1);
        chk("wake magic", 32'(1), 32'(wake));
        wr(pidx(2, `PWIL_OFS_WAKE_EVENT), 8'h04);
        step(1);
        chk("wake cleared", 32'(0), 32'(wake));
        energy <= 7'h01;
        step(1);
        energy <= '0;
        step(1);
        chk("wake energy", 32'(1), 32'(wake));
        wr(pidx(1, `PWIL_OFS_WAKE_EVENT), 8'h01);
        wr(pidx(1, `PWIL_OFS_WAKE_EN), 8'h02);
        energy <= 7'h01;
        step(1);
        energy <= '0;
        step(1);
        chk("wake energy off", 32'(0), 32'(wake));
        linkUp <= 7'h21;
        step(1);
        linkUp <= '0;
        step(1);
        chk("wake link", 32'(1), 32'(wake));
        rdchk("link flag p6", pidx(6, `PWIL_OFS_WAKE_EVENT), 32'h0);
        wr(pidx(1, `PWIL_OFS_WAKE_EVENT), 8'h07);
        step(1);
        chk("wake edges", 32'h3, 32'(wakeCount));
        // Port causes: ACL sticky, mask toggle clears, PHY live
        acl <= 7'h04;
        step(1);
        acl <= '0;
        step(1);
        chk("port irq acl", 32'h04, 32'(portIrq));
        rdchk("status p3", pidx(3, `PWIL_OFS_STATUS), 32'h01);
        rdchk("status p3 again", pidx(3, `PWIL_OFS_STATUS), 32'h01);
        rdchk("status p4", pidx(4, `PWIL_OFS_STATUS), 32'h00);
        wr(pidx(3, `PWIL_OFS_MASK), 8'h01);
        step(1);
        chk("port irq masked", 32'h0, 32'(portIrq));
        rdchk("status p3 clr", pidx(3, `PWIL_OFS_STATUS), 32'h0);
        acl <= 7'h04;
        step(1);
        acl <= '0;
        step(1);
        chk("port irq acl masked", 32'h0, 32'(portIrq));
        rdchk("status p3 held", pidx(3, `PWIL_OFS_STATUS), 32'h01);
        wr(pidx(3, `PWIL_OFS_MASK), 8'h00);
        phyIrq <= 7'h22;
        step(2);
        chk("port irq phy", 32'h02, 32'(portIrq));
        rdchk("status p2", pidx(2, `PWIL_OFS_STATUS), 32'h02);
        rdchk("status p6", pidx(6, `PWIL_OFS_STATUS), 32'h00);
        phyIrq <= '0;
        anDone <= 1'b1;
        step(1);
        anDone <= 1'b0;
        step(1);
        chk("port irq an", 32'h40, 32'(portIrq));
        rdchk("status p7", pidx(7, `PWIL_OFS_STATUS), 32'h08);
        // Global interrupt: raise, clear, count edges
        wr(`PWIL_IDX_GEN, 8'h10);
        acl <= 7'h08;
        step(1);
        acl <= '0;
        step(3);
        chk("irq raised", 32'(1), 32'(irq));
        wr(pidx(4, `PWIL_OFS_MASK), 8'h01);
        wr(`PWIL_IDX_GCLR, 8'hfe);
        step(1);
        chk("irq cleared", 32'(0), 32'(irq));
        chk("irq edges", 32'h1, 32'(irqCount));
        tally_and_finish();
    end
endmodule

`default_nettype wire
